/* File: goc_core.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "goc_map.svh"

module goc_core (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // Register port
    input  wire goc_pkg::goc_addr_t   reg_addr_i,
    input  wire goc_pkg::goc_reg_t    reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output goc_pkg::goc_reg_t         reg_rdata_o,
    // Sample input stream
    input  wire logic                 smp_valid_i,
    output logic                      smp_ready_o,
    input  wire goc_pkg::goc_sample_t smp_data_i,
    input  wire logic                 smp_ch7_i,
    input  wire logic                 smp_even_i,
    // Corrected output stream
    output logic                      out_valid_o,
    input  wire logic                 out_ready_i,
    output goc_pkg::goc_sample_t      out_data_o,
    output logic                      out_ch7_o
);
    import goc_pkg::*;

    // ==================================================
    // Registers
    goc_reg_t    corr_r [4];
    goc_reg_t    ctrl3_r;
    goc_reg_t    rdata_r;
    logic        gain_en;
    logic        offset_en;

    function automatic logic [1:0] addr_slot(input goc_addr_t a);
        addr_slot = 2'(a - `GOC_OFS_CH6_ODD);
    endfunction

    function automatic logic addr_is_corr(input goc_addr_t a);
        addr_is_corr = (a >= `GOC_OFS_CH6_ODD) && (a <= `GOC_OFS_CH7_EVEN);
    endfunction

    wire wr_corr  = reg_wr_i && addr_is_corr(reg_addr_i);
    wire wr_ctrl3 = reg_wr_i && (reg_addr_i == `GOC_OFS_CTRL3);
    wire goc_reg_t rd_mux = addr_is_corr(reg_addr_i) ? corr_r[addr_slot(reg_addr_i)] :
                            (reg_addr_i == `GOC_OFS_CTRL3) ? ctrl3_r : 16'h0000;

    assign gain_en   = ctrl3_r[`GOC_GAIN_EN_BIT];
    assign offset_en = ctrl3_r[`GOC_OFFSET_EN_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_corr
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    corr_r[gi] <= `GOC_CORR_RESET;
                end else if (wr_corr && addr_slot(reg_addr_i) == 2'(gi)) begin
                    corr_r[gi] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl3_r <= `GOC_CTRL3_RESET;
            rdata_r <= 16'h0000;
        end else begin
            if (wr_ctrl3) begin
                ctrl3_r <= reg_wdata_i & `GOC_CTRL3_MASK;
            end
            rdata_r <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata_o = rdata_r;

    // ==================================================
    // Gain table: 10^(N*0.01) in Q2.14, N = 0..31, fixed at elaboration
    logic [16:0] gain_tab [32];
    genvar gn;
    generate
        for (gn = 0; gn < 32; gn++) begin : g_gain
            localparam logic [16:0] GVAL = 17'($rtoi(16384.0 * (10.0 ** (gn * 0.01)) + 0.5));
            assign gain_tab[gn] = GVAL;
        end
    endgenerate

    function automatic logic [16:0] gain_mult(input logic [4:0] n);
        gain_mult = gain_tab[n];
    endfunction

    // ==================================================
    // Datapath, one stage then FIFO then output register
    wire goc_reg_t    coef  = corr_r[{smp_ch7_i, smp_even_i}];
    wire logic [4:0]  gcode = gain_en ? coef[`GOC_GAIN_MSB:`GOC_GAIN_LSB] : 5'h00;
    wire logic signed [15:0] ofs_ext = offset_en ?
        16'(signed'(coef[`GOC_OFFSET_MSB:`GOC_OFFSET_LSB])) : 16'sh0000;
    wire logic signed [15:0] diff = 16'(signed'(smp_data_i)) - ofs_ext;
    wire logic signed [33:0] prod = 34'(diff) * 34'(signed'({1'b0, gain_mult(gcode)}));
    wire logic signed [19:0] scaled = prod[33:14];
    wire goc_sample_t sat =
        (scaled > 20'sh01FFF) ? `GOC_SAT_MAX :
        (scaled < -20'sh02000) ? `GOC_SAT_MIN : scaled[13:0];

    logic        stg_valid_r;
    goc_sample_t stg_data_r;
    logic        stg_ch_r;
    logic        fifo_in_ready;
    wire         stg_take = smp_valid_i && smp_ready_o;

    // Stage drains into FIFO; stall propagates back to the source
    assign smp_ready_o = !stg_valid_r || fifo_in_ready;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stg_valid_r <= 1'b0;
            stg_data_r  <= 14'h0000;
            stg_ch_r    <= 1'b0;
        end else if (smp_ready_o) begin
            stg_valid_r <= smp_valid_i;
            if (stg_take) begin
                stg_data_r <= sat;
                stg_ch_r   <= smp_ch7_i;
            end
        end
    end

    logic              f_valid;
    logic [14:0]       f_data;
    logic              ovalid_r;
    goc_sample_t       odata_r;
    logic              och_r;
    wire               f_pop = f_valid && (!ovalid_r || out_ready_i);

    goc_fifo #(
        .WIDTH(15),
        .DEPTH(`GOC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (stg_valid_r),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({stg_ch_r, stg_data_r}),
        .out_valid_o (f_valid),
        .out_ready_i (!ovalid_r || out_ready_i),
        .out_data_o  (f_data)
    );

    // Output register keeps outputs straight from flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ovalid_r <= 1'b0;
            odata_r  <= 14'h0000;
            och_r    <= 1'b0;
        end else if (!ovalid_r || out_ready_i) begin
            ovalid_r <= f_valid;
            if (f_pop) begin
                odata_r <= f_data[13:0];
                och_r   <= f_data[14];
            end
        end
    end
    assign out_valid_o = ovalid_r;
    assign out_data_o  = odata_r;
    assign out_ch7_o   = och_r;

    // ==================================================
    // Checks
    property p_bypass;
        @(posedge clk_i) disable iff (srst_i)
        (stg_take && !gain_en && !offset_en) |=> (stg_data_r == $past(smp_data_i));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered sample");

    property p_gain_off_ignores_code;
        @(posedge clk_i) disable iff (srst_i)
        !gain_en |-> gcode == 5'h00;
    endproperty
    a_gain_off_ignores_code: assert property (p_gain_off_ignores_code) else $error("gain applied while off");

    property p_gain_monotone;
        @(posedge clk_i) disable iff (srst_i)
        (gain_en && gcode != 5'h00) |-> gain_mult(gcode) > gain_mult(gcode - 5'h01);
    endproperty
    a_gain_monotone: assert property (p_gain_monotone) else $error("gain table not rising");

    property p_offset_only;
        @(posedge clk_i) disable iff (srst_i)
        (stg_take && !gain_en && offset_en && diff <= 16'sh1FFF && diff >= -16'sh2000)
        |=> stg_data_r == $past(diff[13:0]);
    endproperty
    a_offset_only: assert property (p_offset_only) else $error("offset subtract wrong");

    property p_offset_sign;
        @(posedge clk_i) disable iff (srst_i)
        (offset_en && coef[9]) |-> ofs_ext < 16'sh0000;
    endproperty
    a_offset_sign: assert property (p_offset_sign) else $error("offset sign lost");

    property p_reg_write_read;
        @(posedge clk_i) disable iff (srst_i)
        (wr_corr ##1 (reg_rd_i && reg_addr_i == $past(reg_addr_i) && !reg_wr_i))
        |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_reg_write_read: assert property (p_reg_write_read) else $error("register readback wrong");

    property p_reset_zero;
        @(posedge clk_i) (!srst_i && $past(srst_i)) |->
            corr_r[0] == 16'h0000 && corr_r[1] == 16'h0000 && corr_r[2] == 16'h0000 && corr_r[3] == 16'h0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not cleared");

    property p_saturate;
        @(posedge clk_i) disable iff (srst_i)
        (stg_take && scaled > 20'sh01FFF) |=> stg_data_r == `GOC_SAT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("no positive saturation");

    c_gain_and_offset: cover property (@(posedge clk_i) stg_take && gain_en && offset_en && gcode == 5'h1F);
    c_sat_low: cover property (@(posedge clk_i) stg_take && scaled < -20'sh02000);
    c_backpressure: cover property (@(posedge clk_i) smp_valid_i && !smp_ready_o);
endmodule

`default_nettype wire

/* File: goc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module goc_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    wire              push;
    wire              pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem[rd_ptr_r];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push && in_ready_o) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push && in_ready_o) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push && in_ready_o) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    // ==================================================
    // Checks
    property p_fifo_no_overflow;
        @(posedge clk_i) disable iff (srst_i)
        count_r == (AW+1)'(DEPTH) |-> !in_ready_o;
    endproperty
    a_fifo_no_overflow: assert property (p_fifo_no_overflow) else $error("fifo full but ready");

    c_fifo_full: cover property (@(posedge clk_i) disable iff (srst_i) !in_ready_o);
endmodule

`default_nettype wire

/* File: goc_map.svh */
`ifndef GOC_MAP_SVH
`define GOC_MAP_SVH

// ==================================================
// Register offsets
`define GOC_ADDR_W          6
`define GOC_OFS_CH6_ODD     6'h1B
`define GOC_OFS_CH6_EVEN    6'h1C
`define GOC_OFS_CH7_ODD     6'h1D
`define GOC_OFS_CH7_EVEN    6'h1E
`define GOC_OFS_CTRL3       6'h03

// ==================================================
// Field positions
`define GOC_GAIN_MSB        15
`define GOC_GAIN_LSB        11
`define GOC_ZERO_BIT        10
`define GOC_OFFSET_MSB      9
`define GOC_OFFSET_LSB      0
`define GOC_GAIN_EN_BIT     12
`define GOC_OFFSET_EN_BIT   8

// ==================================================
// Reset values and sizes
`define GOC_CORR_RESET      16'h0000
`define GOC_CTRL3_RESET     16'h0000
`define GOC_CTRL3_MASK      16'h1100
`define GOC_SAMPLE_W        14
`define GOC_SAT_MAX         14'h1FFF
`define GOC_SAT_MIN         14'h2000
`define GOC_FIFO_DEPTH      8

`endif

/* File: goc_pkg.sv */
package goc_pkg;
    typedef logic [15:0] goc_reg_t;
    typedef logic [13:0] goc_sample_t;
    typedef logic [5:0]  goc_addr_t;
    typedef logic [1:0]  goc_sel_t;
endpackage

/* File: tb_gain_offset_correction_ch6_7.sv */
`timescale 1ns/1ps
`default_nettype none
`include "goc_map.svh"

module tb_gain_offset_correction_ch6_7;
    import goc_pkg::*;
    // ==================================================
    // Stimulus and observation
    logic        clk_i       = 1'b0;
    logic        srst_i      = 1'b1;
    goc_addr_t   reg_addr_i  = '0;
    goc_reg_t    reg_wdata_i = '0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    goc_reg_t    reg_rdata_o;
    logic        smp_valid_i = 1'b0;
    logic        smp_ready_o;
    goc_sample_t smp_data_i  = '0;
    logic        smp_ch7_i   = 1'b0;
    logic        smp_even_i  = 1'b0;
    logic        out_valid_o;
    logic        out_ready_i = 1'b0;
    goc_sample_t out_data_o;
    logic        out_ch7_o;
    int          err_total   = 0;
    int          samples_checked = 0;
    logic [15:0] rnd         = 16'h005A;
    logic [15:0] rdy_s       = 16'h005A;
    goc_reg_t    creg [4];
    goc_reg_t    ctrl        = '0;
    logic        hold_out    = 1'b0;
    logic [14:0] expq [$];

    always #20 clk_i = ~clk_i;

    goc_core u_dut (
        .clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o), .smp_data_i(smp_data_i),
        .smp_ch7_i(smp_ch7_i), .smp_even_i(smp_even_i),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
        .out_data_o(out_data_o), .out_ch7_o(out_ch7_o)
    );

    // ==================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Offset first, then gain, floor shift, clamp to 14 bits
    function automatic logic [14:0] exp_out(input logic [13:0] s, input logic [15:0] r,
                                            input logic [15:0] c, input logic ch7);
        int d;
        int n;
        int g;
        int y;
        d = int'($signed(s));
        if (c[`GOC_OFFSET_EN_BIT]) d = d - $signed(r[9:0]);
        n = c[`GOC_GAIN_EN_BIT] ? int'(r[15:11]) : 0;
        g = $rtoi(16384.0 * (10.0 ** (n * 0.01)) + 0.5);
        y = (d * g) >>> 14;
        if (y > 8191) y = 8191;
        if (y < -8192) y = -8192;
        return {ch7, y[13:0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Extra idle cycle keeps two writes from touching the strobe in one step
    task automatic wr(input goc_addr_t a, input goc_reg_t d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input goc_addr_t a, input goc_reg_t e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge clk_i);
        check(reg_rdata_o, e);
        @(posedge clk_i);
    endtask

    task automatic send(input logic [13:0] s, input logic ch7, input logic even);
        smp_valid_i <= 1'b1;
        smp_data_i  <= s;
        smp_ch7_i   <= ch7;
        smp_even_i  <= even;
        @(negedge clk_i);
        while (smp_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        expq.push_back(exp_out(s, creg[{ch7, even}], ctrl, ch7));
    endtask

    task automatic drain;
        int t;
        t = 0;
        while (expq.size() > 0 && t < 300) begin
            @(posedge clk_i);
            t++;
        end
        check(16'(expq.size()), 16'h0000);
    endtask

    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            send((i == 0) ? 14'h1FFF : (i == 1) ? 14'h2000 : rnd[13:0], rnd[14], rnd[15]);
        end
        smp_valid_i <= 1'b0;
    endtask

    // ==================================================
    // Output side with random stalls
    always @(posedge clk_i) begin
        rdy_s       <= lfsr(rdy_s);
        out_ready_i <= !hold_out && (rdy_s[0] | rdy_s[3]);
        if (!srst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            check({1'b0, out_ch7_o, out_data_o}, (expq.size() > 0) ? {1'b0, expq.pop_front()} : 16'hFFFF);
        end
    end

    // ==================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int k = 0; k < 4; k++) rd(6'(`GOC_OFS_CH6_ODD + k), `GOC_CORR_RESET);
        rd(`GOC_OFS_CTRL3, 16'h0000);
        rd(6'h00, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            creg[k] = (k == 0) ? 16'hFA00 : (k == 3) ? 16'h01FF : (rnd & 16'hFBFF);
            wr(6'(`GOC_OFS_CH6_ODD + k), creg[k]);
        end
        wr(6'h3F, 16'hFFFF);
        for (int k = 0; k < 4; k++) rd(6'(`GOC_OFS_CH6_ODD + k), creg[k]);
        rd(6'h3F, 16'h0000);
        // Write then read the same register with no gap
        reg_addr_i  <= `GOC_OFS_CH7_EVEN;
        reg_wdata_i <= 16'h0155;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b1;
        @(posedge clk_i);
        reg_rd_i    <= 1'b0;
        @(negedge clk_i);
        check(reg_rdata_o, 16'h0155);
        @(posedge clk_i);
        wr(`GOC_OFS_CH7_EVEN, creg[3]);
        for (int m = 0; m < 4; m++) begin
            ctrl = {3'b000, m[1], 3'b000, m[0], 8'h00};
            wr(`GOC_OFS_CTRL3, ctrl);
            rd(`GOC_OFS_CTRL3, ctrl);
            run(24);
            drain();
        end
        // Fill stage and FIFO with the output blocked
        hold_out = 1'b1;
        fork
            run(14);
            begin
                repeat (30) @(posedge clk_i);
                check({15'h0000, smp_ready_o}, 16'h0000);
                hold_out = 1'b0;
            end
        join
        drain();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
endmodule

`default_nettype wire
